// *** design/iosad_decoder.sv ***
// iosad_decoder: decodes core accesses to i/o space and holds three storage bytes
// assumes the core presents one access per cycle, held for one cycle only
`default_nettype none

// Notes on behaviour
// [R1] software writes zero to reserved bits; stored as written where it has storage
// [R2] software never writes reserved i/o addresses; such writes are dropped anyway
// [R3] bit set and clear reach only i/o addresses 0x00 to 0x1F
// [R4] bit test on the low 32 addresses reports the selected bit for skipping
// [R5] write-one-to-clear flags clear on one and keep their value on zero
// [R6] bit set or clear changes only the addressed bit, never others
// [R7] short i/o read and write use i/o addresses 0x00 to 0x3F
// [R8] data address equals i/o address plus 0x20 for the same register
// [R9] extended data addresses 0x60 to 0xFF are reachable by load and store only
// [R10] three freely read and written storage bytes at 0x19, 0x1A, 0x1B
// [R11] reserved addresses read zero and writes to them have no effect
module iosad_decoder #(
  parameter int unsigned FLAG_W = 8
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // core access
  input wire iosad_pkg::iosad_op_e op_i,
  input wire logic [8:0] addr_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic [7:0] wdata_i,
  // read answer, one cycle after the access
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic bit_test_o,
  output logic skip_if_set_o,
  // extended window strobes to peripheral units
  output logic ext_sel_o,
  output logic ext_write_o,
  // i/o window strobe to peripheral units, with register index
  output logic io_sel_o,
  output logic [5:0] io_index_o,
  // write-one-to-clear flag byte, set by hardware
  input wire logic [7:0] flag_set_i,
  input wire logic [5:0] flag_ofs_i,
  output logic [7:0] flag_o
);
  // refuse flag widths that the byte-wide flag logic cannot serve
  if (FLAG_W != 8) begin : g_flag_w_bad
    $error("flag register must be eight bits wide");
  end

  typedef struct packed {
    logic [7:0] gp0;
    logic [7:0] gp1;
    logic [7:0] gp2;
    logic [7:0] flags;
    logic [7:0] rdata;
    logic rvalid;
    logic test;
    logic ext_sel;
    logic ext_wr;
    logic io_sel;
    logic [5:0] io_index;
  } iosad_state_s;

  iosad_state_s st;
  iosad_state_s next_st;

  // true when the index is within the bit-accessible window
  function automatic logic iosad_bit_ok(input logic [5:0] idx);
    return idx <= iosad_pkg::BIT_LAST;
  endfunction : iosad_bit_ok

  // read value of an i/o index, zero for unmapped ones
  function automatic logic [7:0] iosad_rd(input iosad_state_s s, input logic [5:0] idx,
                                          input logic [5:0] fofs);
    logic [7:0] v;
    v = 8'h00;
    if (idx == iosad_pkg::GP_STORE_0_OFS) v = s.gp0;
    else if (idx == iosad_pkg::GP_STORE_1_OFS) v = s.gp1;
    else if (idx == iosad_pkg::GP_STORE_2_OFS) v = s.gp2;
    else if (idx == fofs) v = s.flags;
    return v; // see [R11]
  endfunction : iosad_rd

  logic is_io_op;
  logic is_data_op;
  logic is_bit_op;
  logic is_wr;
  logic in_io;
  logic in_ext;
  logic [5:0] idx;
  logic [8:0] data_off;
  logic [7:0] cur;
  logic [7:0] wval;
  logic [7:0] bmask;
  logic hit;

  // address views
  always_comb begin
    is_io_op = (op_i == iosad_pkg::IOSAD_OP_IO_READ) || (op_i == iosad_pkg::IOSAD_OP_IO_WRITE);
    is_data_op = (op_i == iosad_pkg::IOSAD_OP_DATA_LOAD) ||
                 (op_i == iosad_pkg::IOSAD_OP_DATA_STORE);
    is_bit_op = (op_i == iosad_pkg::IOSAD_OP_SET_BIT) ||
                (op_i == iosad_pkg::IOSAD_OP_CLEAR_BIT) ||
                (op_i == iosad_pkg::IOSAD_OP_TEST_BIT);
    is_wr = (op_i == iosad_pkg::IOSAD_OP_IO_WRITE) || (op_i == iosad_pkg::IOSAD_OP_DATA_STORE);
    data_off = addr_i - iosad_pkg::DATA_IO_BASE; // see [R8]
    idx = 6'h00;
    in_io = 1'b0;
    in_ext = 1'b0;
    if (is_io_op || is_bit_op) begin
      idx = addr_i[5:0]; // see [R7]
      in_io = (addr_i[8:6] == 3'h0) && (is_io_op || iosad_bit_ok(addr_i[5:0])); // see [R3]
    end else if (is_data_op) begin
      if (addr_i >= iosad_pkg::DATA_IO_BASE && addr_i < iosad_pkg::DATA_EXT_FIRST) begin
        idx = data_off[5:0]; // see [R8]
        in_io = 1'b1;
      end
      in_ext = addr_i >= iosad_pkg::DATA_EXT_FIRST &&
               addr_i <= iosad_pkg::DATA_EXT_LAST; // see [R9]
    end
    cur = iosad_rd(st, idx, flag_ofs_i);
    bmask = 8'h01 << bit_sel_i;
    hit = in_io && (idx <= iosad_pkg::IO_LAST);
  end

  // next state
  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.test = 1'b0;
    next_st.ext_sel = in_ext; // see [R9]
    next_st.ext_wr = in_ext && is_wr;
    next_st.io_sel = hit;
    next_st.io_index = idx;
    wval = wdata_i;
    // flag bits set by hardware after software clearing; set wins
    if (hit && idx == flag_ofs_i && (is_wr || op_i == iosad_pkg::IOSAD_OP_CLEAR_BIT ||
        op_i == iosad_pkg::IOSAD_OP_SET_BIT)) begin
      if (is_wr) next_st.flags = st.flags & ~wdata_i; // see [R5]
      else if (op_i == iosad_pkg::IOSAD_OP_SET_BIT)
        next_st.flags = st.flags & ~bmask; // see [R6]
    end
    next_st.flags = next_st.flags | flag_set_i; // see [R5]
    if (hit && op_i == iosad_pkg::IOSAD_OP_SET_BIT) wval = cur | bmask; // see [R6]
    if (hit && op_i == iosad_pkg::IOSAD_OP_CLEAR_BIT) wval = cur & ~bmask; // see [R6]
    if (hit && (is_wr || op_i == iosad_pkg::IOSAD_OP_SET_BIT ||
        op_i == iosad_pkg::IOSAD_OP_CLEAR_BIT)) begin
      if (idx == iosad_pkg::GP_STORE_0_OFS) next_st.gp0 = wval; // see [R10]
      if (idx == iosad_pkg::GP_STORE_1_OFS) next_st.gp1 = wval; // see [R10]
      if (idx == iosad_pkg::GP_STORE_2_OFS) next_st.gp2 = wval; // see [R10]
    end
    if (op_i == iosad_pkg::IOSAD_OP_IO_READ || op_i == iosad_pkg::IOSAD_OP_DATA_LOAD ||
        op_i == iosad_pkg::IOSAD_OP_TEST_BIT) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = hit ? cur : 8'h00; // see [R11]
      next_st.test = hit && cur[bit_sel_i]; // see [R4]
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign rdata_o = st.rdata;
  assign rvalid_o = st.rvalid;
  assign bit_test_o = st.test;
  assign skip_if_set_o = st.test;
  assign ext_sel_o = st.ext_sel;
  assign ext_write_o = st.ext_wr;
  assign io_sel_o = st.io_sel;
  assign io_index_o = st.io_index;
  assign flag_o = st.flags;

  // checks
  chk_bit_window: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // see [R3]
    (is_bit_op && addr_i[5:0] > iosad_pkg::BIT_LAST) |=> !io_sel_o)
    else $error("bit access reached above 0x1F");
  chk_gp_roundtrip: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // see [R10]
    (op_i == iosad_pkg::IOSAD_OP_IO_WRITE && addr_i == 9'h019)
    |=> (st.gp0 == $past(wdata_i)))
    else $error("storage byte 0 did not take write");
  chk_data_alias: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // see [R8]
    (op_i == iosad_pkg::IOSAD_OP_DATA_LOAD && addr_i == 9'h03A) |=> (rdata_o == st.gp1))
    else $error("data alias of storage byte 1 wrong");
  chk_ext_only_data: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // see [R9]
    (is_io_op || is_bit_op) |=> !ext_sel_o)
    else $error("extended window reached by short access");
  chk_set_one_bit: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // see [R6]
    (op_i == iosad_pkg::IOSAD_OP_SET_BIT && addr_i == 9'h01A)
    |=> (st.gp1 == ($past(st.gp1) | (8'h01 << $past(bit_sel_i)))))
    else $error("bit set changed other bits");
  chk_flag_w1c: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // see [R5]
    (is_wr && hit && idx == flag_ofs_i)
    |=> (flag_o == (($past(st.flags) & ~$past(wdata_i)) | $past(flag_set_i))))
    else $error("flag clear on one failed");
  chk_unmapped_zero: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // see [R11]
    (op_i == iosad_pkg::IOSAD_OP_IO_READ && addr_i == 9'h03C && flag_ofs_i != 6'h3C)
    |=> (rdata_o == 8'h00))
    else $error("reserved address read nonzero");
  chk_bit_test: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // see [R4]
    (op_i == iosad_pkg::IOSAD_OP_TEST_BIT && addr_i == 9'h019)
    |=> (bit_test_o == st.gp0[$past(bit_sel_i)]))
    else $error("bit test answer wrong");
  chk_flag_bit_only: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // see [R6]
    (op_i == iosad_pkg::IOSAD_OP_SET_BIT && hit && idx == flag_ofs_i)
    |=> (flag_o == (($past(st.flags) & ~(8'h01 << $past(bit_sel_i))) | $past(flag_set_i))))
    else $error("bit set on flag byte touched other flags");
  chk_flag_zero_keeps: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // see [R5]
    (op_i == iosad_pkg::IOSAD_OP_CLEAR_BIT && hit && idx == flag_ofs_i)
    |=> (flag_o == ($past(st.flags) | $past(flag_set_i))))
    else $error("bit clear on flag byte changed a flag");
  chk_short_read: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i) // see [R7]
    (op_i == iosad_pkg::IOSAD_OP_IO_READ && addr_i[8:6] == 3'h0)
    |=> (rvalid_o && io_sel_o && io_index_o == $past(addr_i[5:0])))
    else $error("short read did not reach its i/o index");
  cov_io_write: cover property (@(posedge clk_sys_i) op_i == iosad_pkg::IOSAD_OP_IO_WRITE && hit);
  cov_flag_clear: cover property (@(posedge clk_sys_i)
    op_i == iosad_pkg::IOSAD_OP_SET_BIT && hit && idx == flag_ofs_i);
  cov_ext_store: cover property (@(posedge clk_sys_i) ext_write_o);
  cov_skip: cover property (@(posedge clk_sys_i) bit_test_o);
endmodule : iosad_decoder
`default_nettype wire

// *** design/iosad_pkg.sv ***
// iosad_pkg: constants for the i/o space access decoder
// assumes a single core clock and an active-low asynchronous reset
`default_nettype none
package iosad_pkg;
  // access kinds issued by the core
  typedef enum logic [2:0] {
    IOSAD_OP_NONE = 3'h0,
    IOSAD_OP_IO_READ = 3'h1,
    IOSAD_OP_IO_WRITE = 3'h2,
    IOSAD_OP_DATA_LOAD = 3'h3,
    IOSAD_OP_DATA_STORE = 3'h4,
    IOSAD_OP_SET_BIT = 3'h5,
    IOSAD_OP_CLEAR_BIT = 3'h6,
    IOSAD_OP_TEST_BIT = 3'h7
  } iosad_op_e;
  // address windows
  localparam logic [5:0] IO_LAST = 6'h3F;
  localparam logic [5:0] BIT_LAST = 6'h1F;
  localparam logic [8:0] DATA_IO_BASE = 9'h020;
  localparam logic [8:0] DATA_EXT_FIRST = 9'h060;
  localparam logic [8:0] DATA_EXT_LAST = 9'h0FF;
  // general purpose store offsets
  localparam logic [5:0] GP_STORE_0_OFS = 6'h19;
  localparam logic [5:0] GP_STORE_1_OFS = 6'h1A;
  localparam logic [5:0] GP_STORE_2_OFS = 6'h1B;
  localparam logic [7:0] GP_STORE_RESET = 8'h00;
endpackage : iosad_pkg
`default_nettype wire

// *** verif/iosad_core_model.sv ***
// iosad_core_model: core side that issues one i/o space access per call
// assumes the decoder takes an access at the rising edge where op is not idle
`default_nettype none
module iosad_core_model (
  // clock
  input wire logic clk_sys_i,
  // access lines to the decoder
  output var iosad_pkg::iosad_op_e op_o,
  output logic [8:0] addr_o,
  output logic [2:0] bit_sel_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle lines at time zero
  initial begin
    op_o = iosad_pkg::IOSAD_OP_NONE;
    addr_o = 9'h000;
    bit_sel_o = 3'h0;
    wdata_o = 8'h00;
  end
  // one access held for one cycle; callers keep writes off reserved places except the bit sets at 0x01F and 0x020
  task automatic access(input iosad_pkg::iosad_op_e op, input logic [8:0] addr,
      input logic [2:0] bsel, input logic [7:0] wd);
    @(posedge clk_sys_i);
    op_o <= op;
    addr_o <= addr;
    bit_sel_o <= bsel;
    wdata_o <= wd;
    @(posedge clk_sys_i);
    op_o <= iosad_pkg::IOSAD_OP_NONE;
    addr_o <= ~addr; // released lines no longer show the access
    wdata_o <= ~wd;
  endtask : access
endmodule : iosad_core_model
`default_nettype wire

// *** verif/io_space_access_decoder_bench.sv ***
// io_space_access_decoder_bench: table of accesses, then reset and edge cases
// assumes one-cycle answers; flag byte placed at i/o index 0x05
`default_nettype none
module io_space_access_decoder_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    iosad_pkg::iosad_op_e op;
    logic [8:0] addr;
    logic [2:0] bsel;
    logic [7:0] wd;
    logic rv;
    logic [7:0] rd;
    logic ext;
  } iosad_row_s;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] flag_set = 8'h00;
  iosad_pkg::iosad_op_e op;
  logic [8:0] addr;
  logic [2:0] bsel;
  logic [7:0] wd, rdata, flag;
  logic rvalid, bit_test, skip_set, ext_sel, ext_write, io_sel;
  logic [5:0] io_index;
  int error_cnt = 0;
  int n_checks = 0;
  iosad_row_s rows [14] = '{
    '{iosad_pkg::IOSAD_OP_IO_WRITE, 9'h019, 3'h0, 8'hA5, 1'b0, 8'h00, 1'b0},
    '{iosad_pkg::IOSAD_OP_DATA_STORE, 9'h03A, 3'h0, 8'h3C, 1'b0, 8'h00, 1'b0},
    '{iosad_pkg::IOSAD_OP_DATA_STORE, 9'h03B, 3'h0, 8'hFF, 1'b0, 8'h00, 1'b0},
    '{iosad_pkg::IOSAD_OP_DATA_LOAD, 9'h039, 3'h0, 8'h00, 1'b1, 8'hA5, 1'b0},
    '{iosad_pkg::IOSAD_OP_IO_READ, 9'h01A, 3'h0, 8'h00, 1'b1, 8'h3C, 1'b0},
    '{iosad_pkg::IOSAD_OP_SET_BIT, 9'h01A, 3'h0, 8'h00, 1'b0, 8'h00, 1'b0},
    '{iosad_pkg::IOSAD_OP_IO_READ, 9'h01A, 3'h0, 8'h00, 1'b1, 8'h3D, 1'b0},
    '{iosad_pkg::IOSAD_OP_CLEAR_BIT, 9'h01B, 3'h7, 8'h00, 1'b0, 8'h00, 1'b0},
    '{iosad_pkg::IOSAD_OP_DATA_LOAD, 9'h03B, 3'h0, 8'h00, 1'b1, 8'h7F, 1'b0},
    '{iosad_pkg::IOSAD_OP_IO_READ, 9'h03C, 3'h0, 8'h00, 1'b1, 8'h00, 1'b0},
    '{iosad_pkg::IOSAD_OP_DATA_LOAD, 9'h080, 3'h0, 8'h00, 1'b1, 8'h00, 1'b1},
    '{iosad_pkg::IOSAD_OP_DATA_STORE, 9'h060, 3'h0, 8'h11, 1'b0, 8'h00, 1'b1},
    '{iosad_pkg::IOSAD_OP_DATA_LOAD, 9'h0FF, 3'h0, 8'h00, 1'b1, 8'h00, 1'b1},
    '{iosad_pkg::IOSAD_OP_IO_READ, 9'h019, 3'h0, 8'h00, 1'b1, 8'hA5, 1'b0}};
  // core clock, 20 ns period
  always #10 clk_sys_i = ~clk_sys_i;
  iosad_core_model core (.clk_sys_i(clk_sys_i), .op_o(op), .addr_o(addr),
    .bit_sel_o(bsel), .wdata_o(wd));
  iosad_decoder DUT (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .op_i(op),
    .addr_i(addr), .bit_sel_i(bsel), .wdata_i(wd), .rdata_o(rdata), .rvalid_o(rvalid),
    .bit_test_o(bit_test), .skip_if_set_o(skip_set), .ext_sel_o(ext_sel),
    .ext_write_o(ext_write), .io_sel_o(io_sel), .io_index_o(io_index), .flag_set_i(flag_set),
    .flag_ofs_i(6'h05), .flag_o(flag));
  // compare one value against its expectation
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // one access, then settle past the answer edge
  task automatic go(input iosad_pkg::iosad_op_e o, input logic [8:0] a,
      input logic [2:0] b, input logic [7:0] w);
    core.access(o, a, b, w);
    #1;
  endtask : go
  // counts and verdict, end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  // watchdog far beyond the expected run
  initial begin
    #40000;
    error_cnt++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    foreach (rows[i]) begin
      go(rows[i].op, rows[i].addr, rows[i].bsel, rows[i].wd);
      chk("rvalid", {7'h00, rvalid}, {7'h00, rows[i].rv});
      if (rows[i].rv) chk("rdata", rdata, rows[i].rd);
      chk("ext_sel", {7'h00, ext_sel}, {7'h00, rows[i].ext});
      chk("ext_write", {7'h00, ext_write},
          {7'h00, rows[i].ext && rows[i].op == iosad_pkg::IOSAD_OP_DATA_STORE});
    end
    $display("table test done");
    go(iosad_pkg::IOSAD_OP_TEST_BIT, 9'h019, 3'h0, 8'h00);
    chk("skip", {6'h00, bit_test, skip_set}, 8'h03);
    go(iosad_pkg::IOSAD_OP_TEST_BIT, 9'h019, 3'h1, 8'h00);
    chk("skip", {6'h00, bit_test, skip_set}, 8'h00);
    go(iosad_pkg::IOSAD_OP_SET_BIT, 9'h01F, 3'h0, 8'h00);
    chk("io_sel", {7'h00, io_sel}, 8'h01);
    chk("io_index", {2'h0, io_index}, 8'h1F);
    go(iosad_pkg::IOSAD_OP_SET_BIT, 9'h020, 3'h0, 8'h00);
    chk("io_sel", {7'h00, io_sel}, 8'h00);
    go(iosad_pkg::IOSAD_OP_DATA_LOAD, 9'h03A, 3'h0, 8'h00);
    chk("alias rdata", rdata, 8'h3D);
    chk("io_index", {2'h0, io_index}, 8'h1A);
    $display("bit test done");
    @(posedge clk_sys_i);
    flag_set <= 8'h81;
    @(posedge clk_sys_i);
    flag_set <= 8'h00;
    go(iosad_pkg::IOSAD_OP_CLEAR_BIT, 9'h005, 3'h7, 8'h00);
    chk("flag", flag, 8'h81);
    go(iosad_pkg::IOSAD_OP_SET_BIT, 9'h005, 3'h0, 8'h00);
    chk("flag", flag, 8'h80);
    go(iosad_pkg::IOSAD_OP_IO_WRITE, 9'h005, 3'h0, 8'h00);
    chk("flag", flag, 8'h80);
    go(iosad_pkg::IOSAD_OP_IO_WRITE, 9'h005, 3'h0, 8'h80);
    chk("flag", flag, 8'h00);
    // hardware set and software clear in one cycle: the set must win
    @(posedge clk_sys_i);
    flag_set <= 8'h01;
    go(iosad_pkg::IOSAD_OP_IO_WRITE, 9'h005, 3'h0, 8'h01);
    chk("flag set wins", flag, 8'h01);
    @(posedge clk_sys_i);
    flag_set <= 8'h00;
    $display("flag test done");
    @(posedge clk_sys_i);
    arst_n_i <= 1'b0;
    @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    go(iosad_pkg::IOSAD_OP_IO_READ, 9'h019, 3'h0, 8'h00);
    chk("store reset", rdata, iosad_pkg::GP_STORE_RESET);
    chk("flag reset", flag, 8'h00);
    $display("reset test done");
    finish_test();
  end
endmodule : io_space_access_decoder_bench
`default_nettype wire
